// ### include/mvlp_pkg.sv
package mvlp_pkg;
	localparam int SYM_W     = 8;
	localparam int NUM_LANES = 4;

	localparam logic [1:0] LANES_1 = 2'h0;
	localparam logic [1:0] LANES_2 = 2'h1;
	localparam logic [1:0] LANES_4 = 2'h2;

	// Control symbol codes seen by the encoder only when the lane flag is set
	localparam logic [7:0] CTL_BLANK_START = 8'h01;
	localparam logic [7:0] CTL_BLANK_END   = 8'h02;
	localparam logic [7:0] CTL_BLANK_FILL  = 8'h03;

	localparam int VBID_VBLANK    = 0;
	localparam int VBID_FIELD     = 1;
	localparam int VBID_INTERLACE = 2;
	localparam int VBID_NOVIDEO   = 3;
	localparam int VBID_MUTE      = 4;
	localparam int VBID_CPSYNC    = 5;

	localparam logic [4:0] REG_CTRL   = 5'h00;
	localparam logic [4:0] REG_MVID   = 5'h04;
	localparam logic [4:0] REG_MAUD   = 5'h08;
	localparam logic [4:0] REG_STATUS = 5'h0C;
	localparam logic [4:0] REG_LINES  = 5'h10;

	localparam int CTRL_LANES     = 0;
	localparam int CTRL_ENABLE    = 2;
	localparam int CTRL_ENHANCED  = 3;
	localparam int CTRL_VIDEO_ON  = 4;
	localparam int CTRL_INTERLACE = 5;
	localparam int CTRL_MUTE      = 6;
	localparam int CTRL_AUDIO_ON  = 7;
	localparam int CTRL_CPSYNC    = 8;
	localparam int CTRL_W         = 9;
	localparam logic [8:0] CTRL_RST = 9'h000;

	localparam int IDLE_PERIOD_SYMBOLS = 8192;
	localparam int CYCLES_PER_SYMBOL   = 1;
	localparam int IDLE_PERIOD_CYCLES  = IDLE_PERIOD_SYMBOLS * CYCLES_PER_SYMBOL;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_DATA = 4'h1,
		ST_BSQ  = 4'h2,
		ST_BF1  = 4'h3,
		ST_BF2  = 4'h4,
		ST_BS2  = 4'h5,
		ST_VBID = 4'h6,
		ST_MVID = 4'h7,
		ST_MAUD = 4'h8
	} mvlp_state_e;

	// Highest lane index in use
	function automatic logic [1:0] mvlp_last_lane(input logic [1:0] cfg);
		case (cfg)
			LANES_4: mvlp_last_lane = 2'h3;
			LANES_2: mvlp_last_lane = 2'h1;
			default: mvlp_last_lane = 2'h0;
		endcase
	endfunction
endpackage

// ### design/mvlp_idle_timer.sv
`timescale 1ns/1ps
module mvlp_idle_timer import mvlp_pkg::*; #(
	parameter int PERIOD = IDLE_PERIOD_CYCLES
) (
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic run_i,
	input  wire logic restart_i,
	output logic      tick_o
);
	localparam int CW = $clog2(PERIOD) + 1;
	localparam logic [CW-1:0] LAST = CW'(PERIOD - 2);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} mvlp_tmr_s;

	mvlp_tmr_s q_r, q_nxt;

	// The restart on each tick holds the count at zero a cycle, so the count ends one short to keep start-to-start at PERIOD
	always_comb begin
		q_nxt = q_r;
		q_nxt.tick = 1'b0;
		if (!run_i || restart_i) begin
			q_nxt.cnt = '0;
		end else if (q_r.cnt == LAST) begin
			q_nxt.tick = 1'b1;
			q_nxt.cnt  = '0;
		end else begin
			q_nxt.cnt = q_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign tick_o = q_r.tick;
endmodule

// ### design/mvlp_lane_gather.sv
`timescale 1ns/1ps
module mvlp_lane_gather import mvlp_pkg::*; (
	input  wire logic                       clock_i,
	input  wire logic                       rst_i,
	input  wire logic [1:0]                 lanes_i,
	input  wire logic                       pix_valid_i,
	input  wire logic [SYM_W-1:0]           pix_data_i,
	input  wire logic                       pix_eol_i,
	input  wire logic                       pix_eof_i,
	input  wire logic                       pix_field_i,
	output logic                            pix_ready_o,
	input  wire logic                       take_i,
	output logic                            word_valid_o,
	output logic [NUM_LANES*SYM_W-1:0]      word_o,
	output logic                            word_last_o,
	output logic                            word_eof_o,
	output logic                            word_field_o
);
	typedef struct packed {
		logic [1:0]                 idx;
		logic [NUM_LANES*SYM_W-1:0] word;
		logic                       valid;
		logic                       last;
		logic                       eof;
		logic                       field;
		logic                       ready;
	} mvlp_gather_s;

	mvlp_gather_s q_r, q_nxt;

	always_comb begin
		q_nxt = q_r;
		if (take_i && q_r.valid) begin
			// Cleared word leaves unfilled lanes at zero for the line's tail
			q_nxt.word  = '0;
			q_nxt.valid = 1'b0;
			q_nxt.ready = 1'b1;
		end else if (pix_valid_i && q_r.ready) begin
			q_nxt.word[q_r.idx*SYM_W +: SYM_W] = pix_data_i;
			if (q_r.idx == mvlp_last_lane(lanes_i) || pix_eol_i) begin
				q_nxt.valid = 1'b1;
				q_nxt.ready = 1'b0;
				q_nxt.last  = pix_eol_i;
				q_nxt.eof   = pix_eol_i && pix_eof_i;
				q_nxt.field = pix_field_i;
				q_nxt.idx   = 2'h0;
			end else begin
				q_nxt.idx = q_r.idx + 2'h1;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			q_r       <= '0;
			q_r.ready <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign pix_ready_o  = q_r.ready;
	assign word_valid_o = q_r.valid;
	assign word_o       = q_r.word;
	assign word_last_o  = q_r.last;
	assign word_eof_o   = q_r.eof;
	assign word_field_o = q_r.field;
endmodule

// ### design/mvlp_packer.sv
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module mvlp_packer import mvlp_pkg::*; #(
	parameter int IDLE_PERIOD = IDLE_PERIOD_CYCLES
) (
	input  wire logic                       clock_i,
	input  wire logic                       rst_i,
	input  wire logic [4:0]                 avs_address_i,
	input  wire logic                       avs_read_i,
	input  wire logic                       avs_write_i,
	input  wire logic [31:0]                avs_writedata_i,
	input  wire logic [3:0]                 avs_byteenable_i,
	output logic [31:0]                     avs_readdata_o,
	output logic                            avs_waitrequest_o,
	input  wire logic                       pix_valid_i,
	input  wire logic [SYM_W-1:0]           pix_data_i,
	input  wire logic                       pix_eol_i,
	input  wire logic                       pix_eof_i,
	input  wire logic                       pix_field_i,
	output logic                            pix_ready_o,
	input  wire logic                       blank_line_i,
	output logic [NUM_LANES*SYM_W-1:0]      lane_sym_o,
	output logic [NUM_LANES-1:0]            lane_ctl_o,
	output logic                            lane_valid_o
);
	typedef struct packed {
		mvlp_state_e                st;
		logic [1:0]                 rep;
		logic [NUM_LANES*SYM_W-1:0] sym;
		logic [NUM_LANES-1:0]       ctl;
		logic                       valid;
		logic [CTRL_W-1:0]          ctrl;
		logic [7:0]                 mvid;
		logic [7:0]                 maud;
		logic                       waitreq;
		logic [31:0]                rdata;
		logic [15:0]                lines;
		logic                       vblank;
		logic                       field;
		logic                       novid;
		logic                       blank_pend;
	} mvlp_top_s;

	mvlp_top_s q_r, q_nxt;

	logic                       w_valid;
	logic [NUM_LANES*SYM_W-1:0] w_word;
	logic                       w_last;
	logic                       w_eof;
	logic                       w_field;
	logic                       take;
	logic                       tick;
	logic                       go_bs;
	logic [1:0]                 lanes;
	logic [7:0]                 vbid;

	// Copies one byte to every active lane, zero on the rest
	function automatic logic [NUM_LANES*SYM_W-1:0] fill(input logic [7:0] b, input logic [1:0] cfg);
		fill = '0;
		for (int i = 0; i < NUM_LANES; i++) begin
			if (2'(i) <= mvlp_last_lane(cfg)) begin
				fill[i*SYM_W +: SYM_W] = b;
			end
		end
	endfunction

	function automatic logic [NUM_LANES-1:0] lane_mask(input logic [1:0] cfg);
		case (cfg)
			LANES_4: lane_mask = 4'hF;
			LANES_2: lane_mask = 4'h3;
			default: lane_mask = 4'h1;
		endcase
	endfunction

	// Sequence repeats so each blanking byte goes out four times in all
	function automatic logic [1:0] last_rep(input logic [1:0] cfg);
		case (cfg)
			LANES_4: last_rep = 2'h0;
			LANES_2: last_rep = 2'h1;
			default: last_rep = 2'h3;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	assign lanes = q_r.ctrl[CTRL_LANES +: 2];

	mvlp_lane_gather u_gather (
		.clock_i      (clock_i),
		.rst_i        (rst_i),
		.lanes_i      (lanes),
		.pix_valid_i  (pix_valid_i),
		.pix_data_i   (pix_data_i),
		.pix_eol_i    (pix_eol_i),
		.pix_eof_i    (pix_eof_i),
		.pix_field_i  (pix_field_i),
		.pix_ready_o  (pix_ready_o),
		.take_i       (take),
		.word_valid_o (w_valid),
		.word_o       (w_word),
		.word_last_o  (w_last),
		.word_eof_o   (w_eof),
		.word_field_o (w_field)
	);

	mvlp_idle_timer #(
		.PERIOD (IDLE_PERIOD)
	) u_idle (
		.clock_i   (clock_i),
		.rst_i     (rst_i),
		.run_i     (q_r.ctrl[CTRL_ENABLE] && !q_r.ctrl[CTRL_VIDEO_ON]),
		.restart_i (go_bs),
		.tick_o    (tick)
	);

	always_comb begin
		vbid = 8'h00;
		vbid[VBID_VBLANK]    = q_r.vblank || q_r.novid;
		vbid[VBID_FIELD]     = q_r.field && q_r.ctrl[CTRL_INTERLACE];
		vbid[VBID_INTERLACE] = q_r.ctrl[CTRL_INTERLACE] && !q_r.novid;
		vbid[VBID_NOVIDEO]   = q_r.novid;
		vbid[VBID_MUTE]      = q_r.ctrl[CTRL_MUTE];
		vbid[VBID_CPSYNC]    = q_r.ctrl[CTRL_CPSYNC];
	end

	always_comb begin
		q_nxt       = q_r;
		take        = 1'b0;
		go_bs       = 1'b0;
		q_nxt.valid = 1'b0;
		q_nxt.ctl   = '0;
		q_nxt.sym   = '0;

		// Bus: answer one cycle after the request, write lands at the edge that ends the answer
		q_nxt.waitreq = 1'b1;
		q_nxt.rdata   = 32'h0000_0000;
		if ((avs_read_i || avs_write_i) && q_r.waitreq) begin
			q_nxt.waitreq = 1'b0;
			case (avs_address_i)
				REG_CTRL:   q_nxt.rdata = 32'(q_r.ctrl);
				REG_MVID:   q_nxt.rdata = 32'(q_r.mvid);
				REG_MAUD:   q_nxt.rdata = 32'(q_r.maud);
				REG_STATUS: q_nxt.rdata = 32'({q_r.field, q_r.vblank, w_valid, q_r.st});
				REG_LINES:  q_nxt.rdata = 32'(q_r.lines);
				default:    q_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (avs_write_i && !q_r.waitreq) begin
			case (avs_address_i)
				REG_CTRL: q_nxt.ctrl = CTRL_W'(merge(32'(q_r.ctrl), avs_writedata_i, avs_byteenable_i));
				REG_MVID: q_nxt.mvid = 8'(merge(32'(q_r.mvid), avs_writedata_i, avs_byteenable_i));
				REG_MAUD: q_nxt.maud = 8'(merge(32'(q_r.maud), avs_writedata_i, avs_byteenable_i));
				default:  q_nxt.lines = q_r.lines;
			endcase
		end

		case (q_r.st)
			ST_IDLE: begin
				if (q_r.ctrl[CTRL_ENABLE]) begin
					if (q_r.ctrl[CTRL_VIDEO_ON] && w_valid) begin
						// Wait for a whole first word so data follows the end symbol at once
						q_nxt.sym    = fill(CTL_BLANK_END, lanes);
						q_nxt.ctl    = lane_mask(lanes);
						q_nxt.valid  = 1'b1;
						q_nxt.vblank = 1'b0;
						q_nxt.st     = ST_DATA;
					end else if (q_r.ctrl[CTRL_VIDEO_ON] ? q_r.blank_pend : tick) begin
						go_bs = 1'b1;
					end
				end
			end
			ST_DATA: begin
				if (w_valid) begin
					take        = 1'b1;
					q_nxt.sym   = w_word;
					q_nxt.valid = 1'b1;
					if (w_last) begin
						q_nxt.st    = ST_BSQ;
						q_nxt.lines = q_r.lines + 16'h0001;
						if (w_eof) begin
							q_nxt.vblank = 1'b1;
							q_nxt.field  = w_field;
						end
					end
				end
			end
			ST_BSQ: begin
				go_bs = 1'b1;
			end
			ST_BF1, ST_BF2: begin
				q_nxt.sym   = fill(CTL_BLANK_FILL, lanes);
				q_nxt.ctl   = lane_mask(lanes);
				q_nxt.valid = 1'b1;
				q_nxt.st    = (q_r.st == ST_BF1) ? ST_BF2 : ST_BS2;
			end
			ST_BS2: begin
				q_nxt.sym   = fill(CTL_BLANK_START, lanes);
				q_nxt.ctl   = lane_mask(lanes);
				q_nxt.valid = 1'b1;
				q_nxt.st    = ST_VBID;
			end
			ST_VBID: begin
				q_nxt.sym   = fill(vbid, lanes);
				q_nxt.valid = 1'b1;
				q_nxt.st    = ST_MVID;
			end
			ST_MVID: begin
				// Video stamp is forced to zero whenever no video rides the link
				q_nxt.sym   = fill(q_r.novid ? 8'h00 : q_r.mvid, lanes);
				q_nxt.valid = 1'b1;
				q_nxt.st    = ST_MAUD;
			end
			ST_MAUD: begin
				q_nxt.sym   = fill(q_r.ctrl[CTRL_AUDIO_ON] ? q_r.maud : 8'h00, lanes);
				q_nxt.valid = 1'b1;
				if (q_r.rep == last_rep(lanes)) begin
					q_nxt.rep = 2'h0;
					q_nxt.st  = ST_IDLE;
				end else begin
					q_nxt.rep = q_r.rep + 2'h1;
					q_nxt.st  = ST_VBID;
				end
			end
			default: begin
				q_nxt.st = ST_IDLE;
			end
		endcase

		// A request landing in the same cycle as the clear survives
		if (go_bs) begin
			q_nxt.sym        = fill(CTL_BLANK_START, lanes);
			q_nxt.ctl        = lane_mask(lanes);
			q_nxt.valid      = 1'b1;
			q_nxt.novid      = !q_r.ctrl[CTRL_VIDEO_ON];
			q_nxt.rep        = 2'h0;
			q_nxt.blank_pend = 1'b0;
			q_nxt.st         = q_r.ctrl[CTRL_ENHANCED] ? ST_BF1 : ST_VBID;
		end
		if (blank_line_i) begin
			q_nxt.blank_pend = 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			q_r         <= '0;
			q_r.st      <= ST_IDLE;
			q_r.ctrl    <= CTRL_RST;
			q_r.waitreq <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign avs_readdata_o    = q_r.rdata;
	assign avs_waitrequest_o = q_r.waitreq;
	assign lane_sym_o        = q_r.sym;
	assign lane_ctl_o        = q_r.ctl;
	assign lane_valid_o      = q_r.valid;
endmodule

// ### test/mvlp_packer_monitor.sv
`timescale 1ns/1ps
module mvlp_packer_monitor import mvlp_pkg::*; #(
	parameter int IDLE_PERIOD = IDLE_PERIOD_CYCLES
) (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_readdata_o,
	input  wire logic        avs_waitrequest_o,
	input  wire logic        pix_valid_i,
	input  wire logic        pix_eol_i,
	input  wire logic        pix_ready_o,
	input  wire logic [31:0] lane_sym_o,
	input  wire logic [3:0]  lane_ctl_o,
	input  wire logic        lane_valid_o
);
	logic        bs;
	logic        bs_r;
	logic        seen_r;
	logic        ivb;
	logic [15:0] gap_r;
	logic [7:0]  s0;
	assign s0  = lane_sym_o[7:0];
	assign bs  = lane_valid_o && lane_ctl_o[0] && s0 == CTL_BLANK_START;
	assign ivb = bs_r && lane_valid_o && lane_ctl_o == 4'h0 && lane_sym_o[VBID_NOVIDEO];
	// Spacing measured between idle blanking bytes, which equals start to start
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			bs_r   <= 1'b0;
			seen_r <= 1'b0;
			gap_r  <= 16'h0000;
		end else begin
			bs_r   <= bs;
			seen_r <= seen_r | ivb;
			gap_r  <= ivb ? 16'h0001 : gap_r + 16'h0001;
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus answer late");
	AST_WAIT_STANDS: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("bus answer too long");
	AST_RDATA_IDLE: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
		else $error("read data outside answer");
	AST_BE_DATA: assert property (lane_valid_o && lane_ctl_o[0] && s0 == CTL_BLANK_END |=> lane_valid_o && lane_ctl_o == 4'h0)
		else $error("no data after blank end");
	AST_BS_NEXT: assert property (bs |=> lane_valid_o && (lane_ctl_o == 4'h0 || s0 == CTL_BLANK_FILL))
		else $error("bad symbol after blank start");
	AST_CTL_ALL: assert property (lane_valid_o && lane_ctl_o != 4'h0 |-> lane_ctl_o inside {4'h1, 4'h3, 4'hF}
		&& lane_sym_o[15:8] == (lane_ctl_o[1] ? s0 : 8'h00) && lane_sym_o[31:24] == (lane_ctl_o[3] ? s0 : 8'h00))
		else $error("control symbol not on all lanes");
	AST_VBID_BITS: assert property (bs ##1 (lane_valid_o && lane_ctl_o == 4'h0) |-> lane_sym_o[7:6] == 2'b00
		&& (!lane_sym_o[3] || (lane_sym_o[0] && !lane_sym_o[2])))
		else $error("blanking id bits wrong");
	AST_IDLE_MVID: assert property (ivb |=> lane_valid_o && lane_sym_o == 32'h0)
		else $error("video stamp not zero without video");
	AST_EOL_READY: assert property (pix_valid_i && pix_ready_o && pix_eol_i |=> !pix_ready_o)
		else $error("line end did not close word");
	AST_IDLE_GAP: assert property (ivb && seen_r |-> int'(gap_r) == IDLE_PERIOD)
		else $error("idle pattern spacing wrong");
	C_IDLE: cover property (ivb && seen_r);
	C_ENH: cover property (bs ##1 s0 == CTL_BLANK_FILL);
	C_TWO: cover property (lane_valid_o && lane_ctl_o == 4'h3);
endmodule
bind mvlp_packer mvlp_packer_monitor #(.IDLE_PERIOD(IDLE_PERIOD)) u_mon (.clock_i(clock_i), .rst_i(rst_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .pix_valid_i(pix_valid_i), .pix_eol_i(pix_eol_i),
	.pix_ready_o(pix_ready_o), .lane_sym_o(lane_sym_o), .lane_ctl_o(lane_ctl_o), .lane_valid_o(lane_valid_o));

// ### test/mvlp_sink_model.sv
`timescale 1ns/1ps
module mvlp_sink_model import mvlp_pkg::*; (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic [2:0]  nl_i,
	input  wire logic [15:0] apl_i,
	input  wire logic [31:0] lane_sym_i,
	input  wire logic [3:0]  lane_ctl_i,
	input  wire logic        lane_valid_i,
	output logic [15:0]      rx_cnt_o
);
	logic        inl_r;
	logic [15:0] idx_r;
	logic [15:0] left;
	logic [15:0] take;
	assign left = apl_i - idx_r;
	assign take = left < 16'(nl_i) ? left : 16'(nl_i);
	// Padding is told apart only by the line length, never by its value
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			inl_r    <= 1'b0;
			idx_r    <= 16'h0000;
			rx_cnt_o <= 16'h0000;
		end else if (lane_valid_i) begin
			if (lane_ctl_i[0] && lane_sym_i[7:0] == CTL_BLANK_END) begin
				inl_r <= 1'b1;
				idx_r <= 16'h0000;
			end else if (lane_ctl_i != 4'h0) begin
				inl_r <= 1'b0;
			end else if (inl_r) begin
				idx_r    <= idx_r + 16'(nl_i);
				rx_cnt_o <= rx_cnt_o + take;
			end
		end
	end
endmodule

// ### test/mvlp_packer_tb.sv
`timescale 1ns/1ps
module mvlp_packer_tb import mvlp_pkg::*;;
	logic        clock_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [4:0]  avs_address_i = 5'h00;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, lane_sym_o, q, seed = 32'h0000005D;
	logic [3:0]  avs_byteenable_i = 4'hF, lane_ctl_o;
	logic        avs_waitrequest_o, pix_valid_i = 1'b0, pix_eol_i = 1'b0, pix_eof_i = 1'b0;
	logic        pix_field_i = 1'b0, pix_ready_o, blank_line_i = 1'b0, lane_valid_o;
	logic [7:0]  pix_data_i = 8'h00, mvid, maud;
	logic [2:0]  nl = 3'h4;
	logic [15:0] apl = 16'h0000, rx_cnt;
	logic [8:0]  ctrl;
	logic        fld = 1'b0, vbk = 1'b0;
	logic [35:0] expq[$];
	int          error_cnt = 0, n_compared = 0, tot = 0;
	always #2.5 clock_i = ~clock_i;
	mvlp_packer #(.IDLE_PERIOD(64)) u_dut (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i),
		.pix_eol_i(pix_eol_i), .pix_eof_i(pix_eof_i), .pix_field_i(pix_field_i), .pix_ready_o(pix_ready_o),
		.blank_line_i(blank_line_i), .lane_sym_o(lane_sym_o), .lane_ctl_o(lane_ctl_o), .lane_valid_o(lane_valid_o));
	mvlp_sink_model u_sink (.clock_i(clock_i), .rst_i(rst_i), .nl_i(nl), .apl_i(apl), .lane_sym_i(lane_sym_o),
		.lane_ctl_i(lane_ctl_o), .lane_valid_i(lane_valid_o), .rx_cnt_o(rx_cnt));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// One symbol time: byte c on every active lane, inactive lanes zero
	function automatic logic [35:0] lw(input logic k, input logic [7:0] c);
		logic [3:0] m;
		m = nl == 3'h4 ? 4'hF : (nl == 3'h2 ? 4'h3 : 4'h1);
		return {k ? m : 4'h0, {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}} & {4{c}}};
	endfunction
	task automatic chk(input logic [35:0] s, input logic [35:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 400) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address_i   <= a;
		avs_writedata_i <= d;
		avs_write_i     <= w;
		avs_read_i      <= !w;
		do begin
			@(posedge clock_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 400);
		tmo(n);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i  <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (expq.size() > 0 && n < 400) begin
			@(posedge clock_i);
			n++;
		end
		tmo(n);
		repeat (4) @(posedge clock_i);
	endtask
	// Blank start, then the blanking triplet repeated to four copies over all lanes
	task automatic tail(input logic eof, input logic f);
		logic [7:0] vb;
		if (eof) begin
			fld = f;
			vbk = 1'b1;
		end
		vb = {2'b00, ctrl[CTRL_CPSYNC], ctrl[CTRL_MUTE], !ctrl[CTRL_VIDEO_ON],
			ctrl[CTRL_INTERLACE] & ctrl[CTRL_VIDEO_ON], fld & ctrl[CTRL_INTERLACE], vbk | !ctrl[CTRL_VIDEO_ON]};
		expq.push_back(lw(1'b1, CTL_BLANK_START));
		if (ctrl[CTRL_ENHANCED]) begin
			expq.push_back(lw(1'b1, CTL_BLANK_FILL));
			expq.push_back(lw(1'b1, CTL_BLANK_FILL));
			expq.push_back(lw(1'b1, CTL_BLANK_START));
		end
		for (int r = 0; r < 4 / nl; r++) begin
			expq.push_back(lw(1'b0, vb));
			expq.push_back(lw(1'b0, ctrl[CTRL_VIDEO_ON] ? mvid : 8'h00));
			expq.push_back(lw(1'b0, ctrl[CTRL_AUDIO_ON] ? maud : 8'h00));
		end
	endtask
	task automatic line(input int n, input logic eof, input logic f);
		logic [31:0] w;
		int          k, t;
		w = 32'h0;
		apl = 16'(n);
		vbk = 1'b0;
		expq.push_back(lw(1'b1, CTL_BLANK_END));
		for (int i = 0; i < n; i++) begin
			k = i % nl;
			w[8*k+:8] = 8'(rnd());
			pix_data_i  <= w[8*k+:8];
			pix_valid_i <= 1'b1;
			pix_eol_i   <= i == n - 1;
			pix_eof_i   <= eof && i == n - 1;
			pix_field_i <= f;
			t = 0;
			do begin
				@(posedge clock_i);
				t++;
			end while (pix_ready_o !== 1'b1 && t < 400);
			tmo(t);
			if (k == nl - 1 || i == n - 1) begin
				expq.push_back({4'h0, w});
				w = 32'h0;
			end
		end
		pix_valid_i <= 1'b0;
		pix_eol_i   <= 1'b0;
		tot += n;
		tail(eof, f);
		drain();
	endtask
	always @(posedge clock_i) begin
		if (!rst_i && lane_valid_o === 1'b1) begin
			if (expq.size() == 0)
				chk({lane_ctl_o, lane_sym_o}, 36'hF00000000);
			else
				chk({lane_ctl_o, lane_sym_o}, expq.pop_front());
		end
	end
	initial begin
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		bus(1'b0, REG_CTRL, 32'h0);
		chk({4'h0, q}, {27'h0, CTRL_RST});
		bus(1'b1, 5'h14, 32'hFFFFFFFF);
		bus(1'b1, REG_LINES, 32'hFFFFFFFF);
		bus(1'b0, 5'h14, 32'h0);
		chk({4'h0, q}, 36'h0);
		bus(1'b0, REG_LINES, 32'h0);
		chk({4'h0, q}, 36'h0);
		for (int c = 0; c < 3; c++) begin
			q = rnd();
			ctrl = {q[8:6], c != 1, 1'b1, c == 1, 1'b1, c == 0 ? 2'h2 : (c == 1 ? 2'h1 : (q[0] ? 2'h3 : 2'h0))};
			nl = c == 0 ? 3'h4 : (c == 1 ? 3'h2 : 3'h1);
			mvid = 8'(rnd());
			maud = 8'(rnd());
			bus(1'b1, REG_CTRL, {23'h0, ctrl & 9'h003});
			bus(1'b1, REG_MVID, {24'h0, mvid});
			bus(1'b1, REG_MAUD, {24'h0, maud});
			bus(1'b1, REG_CTRL, {23'h0, ctrl});
			bus(1'b0, REG_CTRL, 32'h0);
			chk({4'h0, q}, {27'h0, ctrl});
			line(2 * nl + 1, 1'b1, q[1]);
			tail(1'b0, 1'b0);
			blank_line_i <= 1'b1;
			@(posedge clock_i);
			blank_line_i <= 1'b0;
			drain();
			line(nl, 1'b0, 1'b0);
		end
		ctrl = 9'h086;
		nl = 3'h4;
		bus(1'b1, REG_CTRL, {23'h0, ctrl});
		tail(1'b0, 1'b0);
		tail(1'b0, 1'b0);
		drain();
		bus(1'b1, REG_CTRL, 32'h0);
		chk({20'h0, rx_cnt}, {20'h0, 16'(tot)});
		// Three passes of two lines each must have closed six lines in the counter
		bus(1'b0, REG_LINES, 32'h0);
		chk({4'h0, q}, 36'h000000006);
		tally_and_finish();
	end
endmodule
